// [class_regs.sv]
/*
  class-of-service register bank: thread association and per-class capacity
  masks behind an apb slave, with fault checking and power-state handling.
  assumes apb master on clk and power/smi requests synchronous to clk.
*/
// Summary of operation
// - association and masks readable and writable except while the core is in deep idle, when apb answers are held off
// - write touching reserved bits faults, error code zero
// - mask access beyond highest supported class faults
// - writing class above supported maximum to association faults
// - association read returns currently programmed class
// - mask n read returns bitmask programmed for class n
// - masks are allocation hints only, no coherency role
// - cache shrink or power-off overrides masks
// - after power-off, new fills follow programmed masks
// - cache may be flushed on power-off idle entry
// - association saved on deep core idle entry, restored on exit
// - masks preserved across package idle states
// - system management interrupt leaves all registers unchanged
// - association class field resets to zero
// - class zero mask resets to all ones
// - reported maximum class is zero-based
// - class field sits in upper half of association
`timescale 1ns/10ps
module class_regs #(
  parameter int classes = 16,
  parameter int mask_bits = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power and management requests from the core
  input wire logic core_idle_req,
  input wire logic pkg_idle_req,
  input wire logic cache_shrink_req,
  input wire logic smi_req,
  // allocation hint and flush request to cache, fault flag
  output logic [mask_bits-1:0] alloc_mask,
  output logic alloc_mask_valid,
  output logic cache_flush,
  output logic gp_fault
);

  localparam int idx_bits = $clog2(classes);

  // refuse sizes the decode and the 32-bit bus cannot carry
  if (classes < 2 || classes > 256 || mask_bits < 1 || mask_bits > 32) begin : g_size_check
    $error("class_regs: unsupported classes or mask_bits");
  end

  localparam logic [15:0] max_class = 16'(classes - 1);
  localparam logic [31:0] mask_valid_bits = 32'((64'd1 << mask_bits) - 64'd1);

  // request pins pass two flops
  logic [3:0] req_meta_q;
  logic [3:0] req_sync_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_meta_q <= 4'h0;
      req_sync_q <= 4'h0;
    end else begin
      req_meta_q <= {smi_req, cache_shrink_req, pkg_idle_req, core_idle_req};
      req_sync_q <= req_meta_q;
    end
  end
  logic core_idle_s;
  logic pkg_idle_s;
  logic shrink_s;
  logic smi_s;
  assign core_idle_s = req_sync_q[class_regs_pkg::pwr_core_idle_bit];
  assign pkg_idle_s = req_sync_q[class_regs_pkg::pwr_pkg_idle_bit];
  assign shrink_s = req_sync_q[class_regs_pkg::pwr_shrink_bit];
  assign smi_s = req_sync_q[class_regs_pkg::pwr_smi_bit];

  // apb decode
  class_regs_pkg::reg_req_type req;
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  function automatic logic is_mask(input logic [11:0] a);
    return a >= class_regs_pkg::mask_base_offset && a[1:0] == 2'b00;
  endfunction

  function automatic logic [9:0] mask_index(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - class_regs_pkg::mask_base_offset;
    return rel[11:2];
  endfunction

  logic access;
  assign access = psel && penable && !pready;

  // power state machine for association save and restore
  class_regs_pkg::core_pwr_type pwr_q;
  logic [idx_bits-1:0] class_q;
  logic [idx_bits-1:0] saved_class_q;
  logic [1:0] pwr_cnt_q;
  logic busy;
  assign busy = pwr_q != class_regs_pkg::pwr_active_type;

  // combinational check of the current request
  class_regs_pkg::reg_rsp_type rsp;
  logic [9:0] req_idx;
  logic [mask_bits-1:0] rd_mask;
  logic mask_wr;
  logic assoc_wr;
  assign req_idx = mask_index(req.addr);

  always_comb begin
    rsp = '{rdata: class_regs_pkg::zero_word, fault: 1'b0};
    mask_wr = 1'b0;
    assoc_wr = 1'b0;
    if (is_mask(req.addr)) begin
      if (req_idx > 10'(max_class)) begin
        rsp.fault = 1'b1;
      end else if (req.write) begin
        if ((req.wdata & ~mask_valid_bits) != 32'h0000_0000) begin
          rsp.fault = 1'b1;
        end else begin
          mask_wr = 1'b1;
        end
      end else begin
        rsp.rdata = 32'(rd_mask);
      end
    end else begin
      unique case (req.addr)
        class_regs_pkg::assoc_lo_offset: begin
          if (req.write && req.wdata != class_regs_pkg::zero_word) begin
            rsp.fault = 1'b1;
          end
        end
        class_regs_pkg::assoc_hi_offset: begin
          if (req.write) begin
            if (req.wdata > 32'(max_class)) begin
              rsp.fault = 1'b1;
            end else begin
              assoc_wr = 1'b1;
            end
          end else begin
            rsp.rdata = 32'(class_q) << class_regs_pkg::class_field_lsb;
          end
        end
        class_regs_pkg::status_offset: begin
          rsp.rdata = class_regs_pkg::zero_word;
          rsp.rdata[class_regs_pkg::smm_bit] = smi_s;
          rsp.rdata[class_regs_pkg::deep_idle_bit] = busy;
          rsp.rdata[class_regs_pkg::pkg_idle_bit] = pkg_idle_s;
          rsp.rdata[class_regs_pkg::shrink_bit] = shrink_s;
          rsp.rdata[class_regs_pkg::flush_bit] = cache_flush;
          rsp.rdata[class_regs_pkg::fault_bit] = gp_fault;
          if (req.write) begin
            rsp.fault = 1'b1;
          end
        end
        class_regs_pkg::caps_offset: begin
          rsp.rdata = {16'(mask_bits - 1), max_class};
          if (req.write) begin
            rsp.fault = 1'b1;
          end
        end
        default: begin
          rsp.fault = 1'b1;
        end
      endcase
    end
  end

  // apb answer: one wait state, held off while the core sits in deep idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= class_regs_pkg::zero_word;
    end else if (access && !busy) begin
      pready <= 1'b1;
      pslverr <= rsp.fault;
      prdata <= req.write ? class_regs_pkg::zero_word : rsp.rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // fault flag of the last answered access, read from status; every answered access overwrites it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gp_fault <= 1'b0;
    end else if (access && !busy) begin
      gp_fault <= rsp.fault;
    end
  end

  logic do_write;
  assign do_write = access && !busy && req.write && !rsp.fault;

  // association class register with deep idle save and restore
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      class_q <= '0;
      saved_class_q <= '0;
      pwr_q <= class_regs_pkg::pwr_active_type;
      pwr_cnt_q <= 2'd0;
    end else begin
      unique case (pwr_q)
        class_regs_pkg::pwr_active_type: begin
          if (do_write && assoc_wr) begin
            class_q <= req.wdata[idx_bits-1:0];
          end
          if (core_idle_s) begin
            pwr_q <= class_regs_pkg::pwr_saving_type;
            pwr_cnt_q <= 2'(class_regs_pkg::save_cycles - 1);
          end
        end
        class_regs_pkg::pwr_saving_type: begin
          saved_class_q <= class_q;
          if (pwr_cnt_q == 2'd0) begin
            pwr_q <= class_regs_pkg::pwr_idle_type;
          end else begin
            pwr_cnt_q <= pwr_cnt_q - 2'd1;
          end
        end
        class_regs_pkg::pwr_idle_type: begin
          class_q <= '0;
          if (!core_idle_s) begin
            pwr_q <= class_regs_pkg::pwr_restoring_type;
            pwr_cnt_q <= 2'(class_regs_pkg::save_cycles - 1);
          end
        end
        class_regs_pkg::pwr_restoring_type: begin
          class_q <= saved_class_q;
          if (pwr_cnt_q == 2'd0) begin
            pwr_q <= class_regs_pkg::pwr_active_type;
          end else begin
            pwr_cnt_q <= pwr_cnt_q - 2'd1;
          end
        end
      endcase
    end
  end

  logic [mask_bits-1:0] use_mask;

  class_mask_bank #(
    .classes(classes),
    .mask_bits(mask_bits)
  ) mask_bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_en(do_write && mask_wr),
    .wr_idx(req_idx[idx_bits-1:0]),
    .wr_mask(req.wdata[mask_bits-1:0]),
    .rd_idx(req_idx[idx_bits-1:0]),
    .rd_mask(rd_mask),
    .use_idx(class_q),
    .use_mask(use_mask)
  );

  // allocation hint: masks only steer fills, never coherency
  logic cache_off;
  assign cache_off = shrink_s || pkg_idle_s || busy;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alloc_mask <= {mask_bits{1'b1}};
      alloc_mask_valid <= 1'b0;
    end else begin
      alloc_mask <= use_mask;
      alloc_mask_valid <= !cache_off;
    end
  end

  // flush request on entry to a cache power-off idle state
  logic off_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      off_q <= 1'b0;
      cache_flush <= 1'b0;
    end else begin
      off_q <= pkg_idle_s || core_idle_s;
      cache_flush <= (pkg_idle_s || core_idle_s) && !off_q;
    end
  end

  // smi is only reported; no register reacts to it
  logic smi_unused;
  assign smi_unused = smi_s;

endmodule

// [class_regs_pkg.sv]
/*
  package for the class-of-service register bank: register offsets, field
  layouts, reset values, power states and the carrier structs.
  assumes a 32-bit apb slave with each register word-aligned.
*/
package class_regs_pkg;

  // apb byte offsets (64-bit model registers split into two words)
  localparam logic [11:0] assoc_lo_offset = 12'h000;
  localparam logic [11:0] assoc_hi_offset = 12'h004;
  localparam logic [11:0] status_offset = 12'h008;
  localparam logic [11:0] power_offset = 12'h00C;
  localparam logic [11:0] caps_offset = 12'h010;
  localparam logic [11:0] mask_base_offset = 12'h100;

  // status bits
  localparam int fault_bit = 0;
  localparam int smm_bit = 1;
  localparam int deep_idle_bit = 2;
  localparam int pkg_idle_bit = 3;
  localparam int shrink_bit = 4;
  localparam int flush_bit = 5;

  // power control bits
  localparam int pwr_core_idle_bit = 0;
  localparam int pwr_pkg_idle_bit = 1;
  localparam int pwr_shrink_bit = 2;
  localparam int pwr_smi_bit = 3;

  // class field position in upper association word
  localparam int class_field_lsb = 0;

  // reset values
  localparam logic [31:0] assoc_reset = 32'h0000_0000;
  localparam logic [31:0] ones_reset = 32'hFFFF_FFFF;
  localparam logic [31:0] zero_word = 32'h0000_0000;

  // cycles a save or restore of the association register takes
  localparam int save_cycles = 2;

  typedef enum logic [1:0] {
    pwr_active_type,
    pwr_saving_type,
    pwr_idle_type,
    pwr_restoring_type
  } core_pwr_type;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic fault;
  } reg_rsp_type;

endpackage

// [class_mask_bank.sv]
/*
  capacity bitmask storage for every class of service, flip-flop based.
  assumes the caller has already checked index range and reserved bits.
*/
`timescale 1ns/10ps
module class_mask_bank #(
  parameter int classes = 16,
  parameter int mask_bits = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // write port
  input wire logic wr_en,
  input wire logic [$clog2(classes)-1:0] wr_idx,
  input wire logic [mask_bits-1:0] wr_mask,
  // read ports
  input wire logic [$clog2(classes)-1:0] rd_idx,
  output logic [mask_bits-1:0] rd_mask,
  input wire logic [$clog2(classes)-1:0] use_idx,
  output logic [mask_bits-1:0] use_mask
);

  logic [mask_bits-1:0] mask_q [classes];

  // all masks reset to ones; untouched by idle or smi
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < classes; i++) begin
        mask_q[i] <= {mask_bits{1'b1}};
      end
    end else if (wr_en) begin
      mask_q[wr_idx] <= wr_mask;
    end
  end

  assign rd_mask = mask_q[rd_idx];
  assign use_mask = mask_q[use_idx];

endmodule

// [class_regs_asserts.sv]
/*
  port checker for the class-of-service register bank.
  assumes the apb master holds pwrite through each access.
*/
`timescale 1ns/10ps
module class_regs_asserts #(
  parameter int classes = 16,
  parameter int mask_bits = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // power and cache side
  input wire logic core_idle_req,
  input wire logic cache_shrink_req,
  input wire logic [mask_bits-1:0] alloc_mask,
  input wire logic alloc_mask_valid,
  input wire logic cache_flush,
  input wire logic gp_fault
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence acc_wait;
    psel && penable && !pready && !core_idle_req;
  endsequence
  sequence idle_held;
    core_idle_req [*8];
  endsequence
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_access_done: assert property (acc_wait |-> ##[1:20] pready)
    else $error("access never answered");
  a_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data on a write");
  a_fault_status: assert property (pready |=> gp_fault == $past(pslverr))
    else $error("gp_fault does not follow pslverr");
  a_status_hold: assert property (!pready ##1 !pready |-> $stable(gp_fault))
    else $error("gp_fault changed without access");
  a_flush_pulse: assert property (cache_flush |=> !cache_flush)
    else $error("flush longer than one cycle");
  a_shrink_ignore: assert property (cache_shrink_req [*4] |-> !alloc_mask_valid)
    else $error("mask valid during shrink");
  a_idle_stall: assert property (idle_held |-> !pready)
    else $error("access answered in deep idle");
  a_reset_mask: assert property ($fell(sys_rst) |-> alloc_mask == {mask_bits{1'b1}})
    else $error("mask not all ones after reset");
endmodule

bind class_regs class_regs_asserts #(.classes(classes), .mask_bits(mask_bits)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_idle_req(core_idle_req),
  .cache_shrink_req(cache_shrink_req), .alloc_mask(alloc_mask),
  .alloc_mask_valid(alloc_mask_valid), .cache_flush(cache_flush), .gp_fault(gp_fault));

// [class_regs_tb.sv]
/*
  self-checking bench for class_regs over apb.
  assumes the default sixteen classes of sixteen mask bits.
*/
`timescale 1ns/10ps
module class_regs_tb;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, cache_flush, gp_fault, alloc_mask_valid, er, seen;
  logic core_idle_req = 0, pkg_idle_req = 0, cache_shrink_req = 0, smi_req = 0;
  logic [15:0] alloc_mask;
  logic [31:0] m [16];
  logic [31:0] c;
  int num_errors = 0, tests_run = 0, r;
  always #25 clk = ~clk;
  class_regs #(.classes(16), .mask_bits(16)) DUT (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_idle_req(core_idle_req),
    .pkg_idle_req(pkg_idle_req), .cache_shrink_req(cache_shrink_req), .smi_req(smi_req),
    .alloc_mask(alloc_mask), .alloc_mask_valid(alloc_mask_valid),
    .cache_flush(cache_flush), .gp_fault(gp_fault));
  task automatic give_verdict;
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // values read here are those sampled at this rising edge
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic fe);
    xfer(1, a, d);
    chk(er, fe);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(er, 0);
  endtask
  task automatic all_masks;
    for (int i = 0; i < 16; i++) rdc(class_regs_pkg::mask_base_offset + 12'(4 * i), m[i]);
  endtask
  // pulse watch for idle entry, then check masks are ignored
  task automatic enter_idle;
    seen = 0;
    repeat (8) begin
      @(posedge clk);
      if (cache_flush === 1'b1) seen = 1;
    end
    chk(seen, 1);
    chk(alloc_mask_valid, 0);
  endtask
  initial begin
    r = $urandom(43);
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 16; i++) m[i] = 32'h0000_FFFF;
    rdc(class_regs_pkg::assoc_hi_offset, 32'h0000_0000);
    all_masks();
    rdc(class_regs_pkg::caps_offset, 32'h000F_000F);
    chk(alloc_mask_valid, 1);
    for (int i = 0; i < 16; i++) begin
      m[i] = $urandom & 32'h0000_FFFF;
      wr(class_regs_pkg::mask_base_offset + 12'(4 * i), m[i], 0);
    end
    all_masks();
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? 32'd15 : 32'($urandom_range(15));
      wr(class_regs_pkg::assoc_hi_offset, c, 0);
      rdc(class_regs_pkg::assoc_hi_offset, c);
      chk({16'h0000, alloc_mask}, m[c]);
    end
    wr(class_regs_pkg::assoc_hi_offset, 32'd16, 1);
    wr(class_regs_pkg::assoc_lo_offset, 32'h0000_0001, 1);
    wr(class_regs_pkg::mask_base_offset + 12'h00C, 32'h0001_0000, 1);
    wr(class_regs_pkg::mask_base_offset + 12'h040, 32'h0000_0001, 1);
    wr(class_regs_pkg::power_offset, 32'h0000_0001, 1);
    wr(class_regs_pkg::caps_offset, 32'h0000_0000, 1);
    chk(gp_fault, 1);
    xfer(0, class_regs_pkg::mask_base_offset + 12'h040, 32'h0000_0000);
    chk(er, 1);
    rdc(class_regs_pkg::assoc_hi_offset, c);
    all_masks();
    core_idle_req <= 1;
    enter_idle();
    core_idle_req <= 0;
    repeat (10) @(posedge clk);
    rdc(class_regs_pkg::assoc_hi_offset, c);
    pkg_idle_req <= 1;
    enter_idle();
    pkg_idle_req <= 0;
    repeat (10) @(posedge clk);
    all_masks();
    chk({alloc_mask_valid, 15'h0000, alloc_mask}, {1'b1, 15'h0000, m[c][15:0]});
    cache_shrink_req <= 1;
    repeat (8) @(posedge clk);
    chk(alloc_mask_valid, 0);
    rdc(class_regs_pkg::status_offset, 32'h0000_0010);
    cache_shrink_req <= 0;
    repeat (8) @(posedge clk);
    // shrink off again: masks steer fills once more
    chk(alloc_mask_valid, 1);
    smi_req <= 1;
    repeat (8) @(posedge clk);
    rdc(class_regs_pkg::status_offset, 32'h0000_0002);
    // handler parks on class zero, then puts the old one back
    wr(class_regs_pkg::assoc_hi_offset, 32'd0, 0);
    wr(class_regs_pkg::assoc_hi_offset, c, 0);
    smi_req <= 0;
    repeat (4) @(posedge clk);
    rdc(class_regs_pkg::assoc_hi_offset, c);
    all_masks();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule
